// ===== dbp_pkg.sv
package dbp_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam int          REG_AW      = 8;
  localparam logic [7:0]  R_B_MODE    = 8'h00;
  localparam logic [7:0]  R_B_DIR     = 8'h04;
  localparam logic [7:0]  R_B_OUT     = 8'h08;
  localparam logic [7:0]  R_B_OD      = 8'h0C;
  localparam logic [7:0]  R_B_SLEW    = 8'h10;
  localparam logic [7:0]  R_C_MODE    = 8'h14;
  localparam logic [7:0]  R_C_DIR     = 8'h18;
  localparam logic [7:0]  R_C_OUT     = 8'h1C;
  localparam logic [7:0]  R_C_OD      = 8'h20;
  localparam logic [7:0]  R_C_FUNC    = 8'h24;
  localparam logic [7:0]  R_PIN_IN    = 8'h28;
  localparam logic [7:0]  R_IRQ_STAT  = 8'h2C;
  localparam logic [7:0]  R_IRQ_MASK  = 8'h30;
  localparam logic [7:0]  R_HOST_BASE = 8'h34;

  // ****************************************
  // Field codes and layouts
  // ****************************************
  localparam logic [1:0]  MODE_IO      = 2'h0;
  localparam logic [1:0]  MODE_PLD_OUT = 2'h1;
  localparam logic [1:0]  MODE_PLD_IN  = 2'h2;
  localparam logic [7:0]  B_OD_MASK    = 8'hF8;
  localparam int          F_JTAG       = 0;
  localparam int          F_ENH        = 1;
  localparam int          F_RDYBSY     = 2;
  localparam int          EV_FLASH     = 0;
  localparam int          EV_HWR       = 1;
  localparam int          EV_HRD       = 2;
  localparam int          EV_W         = 3;
  localparam int          BASE_W       = 12;
  localparam int          HADDR_W      = 16;
  localparam int          HOFF_W       = 4;
  localparam logic [3:0]  HO_B_OUT     = 4'h0;
  localparam logic [3:0]  HO_C_OUT     = 4'h1;
  localparam logic [3:0]  HO_B_PIN     = 4'h2;
  localparam logic [3:0]  HO_C_PIN     = 4'h3;
  localparam int          SYNC_W       = 43;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [15:0] mode;
    logic [7:0]  dir;
    logic [7:0]  dout;
    logic [7:0]  od;
  } dbp_port_s;

  localparam dbp_port_s PORT_RST = '0;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_RD   = 3'h2,
    H_WR   = 3'h4
  } dbp_host_e;

endpackage : dbp_pkg

// ===== dbp_sync.sv
`timescale 1ns/1ps
module dbp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,    // Clock
  input  wire logic             aresetn, // Synchronous reset
  input  wire logic             clk_en,  // Clock enable
  input  wire logic [WIDTH-1:0] d,       // Asynchronous inputs
  output logic      [WIDTH-1:0] q        // Synchronised inputs
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else if (clk_en) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : dbp_sync

// ===== dbp_pins.sv
`timescale 1ns/1ps
module dbp_pins
  import dbp_pkg::*;
(
  input  wire logic              aclk,                   // 200 MHz clock
  input  wire logic              aresetn,                // Sync reset
  input  wire logic              clk_en,                 // Clock enable
  input  wire logic [REG_AW-1:0] s_axi_awaddr,           // AXI write addr
  input  wire logic              s_axi_awvalid,          // AXI
  output logic                   s_axi_awready,          // AXI
  input  wire logic [31:0]       s_axi_wdata,            // AXI
  input  wire logic [3:0]        s_axi_wstrb,            // AXI
  input  wire logic              s_axi_wvalid,           // AXI
  output logic                   s_axi_wready,           // AXI
  output logic [1:0]             s_axi_bresp,            // AXI
  output logic                   s_axi_bvalid,           // AXI
  input  wire logic              s_axi_bready,           // AXI
  input  wire logic [REG_AW-1:0] s_axi_araddr,           // AXI read addr
  input  wire logic              s_axi_arvalid,          // AXI
  output logic                   s_axi_arready,          // AXI
  output logic [31:0]            s_axi_rdata,            // AXI
  output logic [1:0]             s_axi_rresp,            // AXI
  output logic                   s_axi_rvalid,           // AXI
  input  wire logic              s_axi_rready,           // AXI
  input  wire logic              write_strobe_in_n,      // Host write
  input  wire logic              read_strobe_in_n,       // Host read
  input  wire logic              byte_space_select_in_n, // Host select
  input  wire logic [HADDR_W-1:0] host_address_in,       // Host address
  input  wire logic [7:0]        host_data_bus_in,       // Data pin in
  output logic      [7:0]        host_data_bus_out,      // Data pin out
  output logic      [7:0]        host_data_bus_oe_n,     // Data pin enable
  input  wire logic [7:0]        port_b_pins_in,         // Port B in
  output logic      [7:0]        port_b_pins_out,        // Port B out
  output logic      [7:0]        port_b_pins_oe_n,       // Port B enable
  output logic      [3:0]        port_b_slew_fast,       // Fast slew
  input  wire logic [7:0]        port_c_pins_in,         // Port C in
  output logic      [7:0]        port_c_pins_out,        // Port C out
  output logic      [7:0]        port_c_pins_oe_n,       // Port C enable
  input  wire logic [7:0]        output_cell_group_one,  // PLD to port B
  input  wire logic [7:0]        output_cell_group_two,  // PLD to port C
  output logic      [7:0]        pld_in_b,               // Port B to PLD
  output logic      [7:0]        pld_in_c,               // Port C to PLD
  output logic                   jtag_tms,               // To JTAG core
  output logic                   jtag_tck,               // To JTAG core
  output logic                   jtag_tdi,               // To JTAG core
  input  wire logic              jtag_tdo,               // From JTAG core
  input  wire logic              prog_status_out,        // Prog status
  input  wire logic              prog_error_out,         // Prog error
  input  wire logic              flash_ready,            // Flash idle
  output logic                   irq                     // Interrupt
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_W-1:0]  sync_q;
  logic               wr_s;
  logic               rd_s;
  logic               bms_s;
  logic [HADDR_W-1:0] addr_s;
  logic [7:0]         hdat_s;
  logic [7:0]         pb_s;
  logic [7:0]         pc_s;

  dbp_sync #(.WIDTH(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .d       ({write_strobe_in_n, read_strobe_in_n, byte_space_select_in_n,
               host_address_in, host_data_bus_in, port_b_pins_in, port_c_pins_in}),
    .q       (sync_q)
  );

  assign {wr_s, rd_s, bms_s, addr_s, hdat_s, pb_s, pc_s} = sync_q;

  // ****************************************
  // Registers and functions
  // ****************************************
  dbp_port_s         pb;
  dbp_port_s         pc;
  logic [3:0]        b_slew;
  logic [2:0]        c_func;
  logic [BASE_W-1:0] host_base;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;
  logic              aw_take;
  logic              ar_take;
  logic [31:0]       rd_word;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic reg_known(input logic [REG_AW-1:0] a);
    logic k;
    k = 1'b0;
    if (a == R_B_MODE || a == R_B_DIR || a == R_B_OUT || a == R_B_OD) begin
      k = 1'b1;
    end else if (a == R_B_SLEW || a == R_C_MODE || a == R_C_DIR || a == R_C_OUT) begin
      k = 1'b1;
    end else if (a == R_C_OD || a == R_C_FUNC || a == R_PIN_IN) begin
      k = 1'b1;
    end else if (a == R_IRQ_STAT || a == R_IRQ_MASK || a == R_HOST_BASE) begin
      k = 1'b1;
    end
    return k;
  endfunction : reg_known

  // Returns {oe_n, out} for one pin. An open drain pin only pulls low.
  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic dir,
                                           input logic dout, input logic pld, input logic od);
    logic drive;
    logic val;
    drive = (mode == MODE_IO && dir) || mode == MODE_PLD_OUT;
    val   = (mode == MODE_PLD_OUT) ? pld : dout;
    return {!(drive && !(od && val)), val};
  endfunction : pin_drive

  // ****************************************
  // Host bus access
  // ****************************************
  dbp_host_e         hs;
  dbp_host_e         next_hs;
  logic              hsel;
  logic [HOFF_W-1:0] hoff;
  logic [7:0]        hwr_data;
  logic [7:0]        h_rdata;
  logic              h_commit;

  assign hsel     = !bms_s && addr_s[HADDR_W-1:HOFF_W] == host_base;
  assign h_commit = (hs == H_WR) && wr_s;

  always_comb begin
    next_hs = hs;
    case (hs)
      H_IDLE: begin
        if (hsel && !rd_s) begin
          next_hs = H_RD;
        end else if (hsel && !wr_s) begin
          next_hs = H_WR;
        end
      end
      H_RD: begin
        if (rd_s || bms_s) begin
          next_hs = H_IDLE;
        end
      end
      H_WR: begin
        if (wr_s) begin
          next_hs = H_IDLE;
        end
      end
      default: next_hs = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs       <= H_IDLE;
      hoff     <= '0;
      hwr_data <= '0;
      h_rdata  <= '0;
    end else if (clk_en) begin
      hs <= next_hs;
      if (hs == H_IDLE) begin
        hoff <= addr_s[HOFF_W-1:0];
      end
      if (next_hs == H_WR && !wr_s) begin
        hwr_data <= hdat_s;
      end
      if (hs == H_IDLE && next_hs == H_RD) begin
        if (addr_s[HOFF_W-1:0] == HO_B_OUT) begin
          h_rdata <= pb.dout;
        end else if (addr_s[HOFF_W-1:0] == HO_C_OUT) begin
          h_rdata <= pc.dout;
        end else if (addr_s[HOFF_W-1:0] == HO_B_PIN) begin
          h_rdata <= pb_s;
        end else if (addr_s[HOFF_W-1:0] == HO_C_PIN) begin
          h_rdata <= pc_s;
        end else begin
          h_rdata <= '0;
        end
      end
    end
  end

  assign host_data_bus_out  = h_rdata;
  assign host_data_bus_oe_n = {8{hs != H_RD}};

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign aw_take       = clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign ar_take       = clk_en && s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = aw_take;
  assign s_axi_wready  = aw_take;
  assign s_axi_arready = ar_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    if (s_axi_araddr == R_B_MODE) begin
      rd_word[15:0] = pb.mode;
    end else if (s_axi_araddr == R_B_DIR) begin
      rd_word[7:0] = pb.dir;
    end else if (s_axi_araddr == R_B_OUT) begin
      rd_word[7:0] = pb.dout;
    end else if (s_axi_araddr == R_B_OD) begin
      rd_word[7:0] = pb.od;
    end else if (s_axi_araddr == R_B_SLEW) begin
      rd_word[3:0] = b_slew;
    end else if (s_axi_araddr == R_C_MODE) begin
      rd_word[15:0] = pc.mode;
    end else if (s_axi_araddr == R_C_DIR) begin
      rd_word[7:0] = pc.dir;
    end else if (s_axi_araddr == R_C_OUT) begin
      rd_word[7:0] = pc.dout;
    end else if (s_axi_araddr == R_C_OD) begin
      rd_word[7:0] = pc.od;
    end else if (s_axi_araddr == R_C_FUNC) begin
      rd_word[2:0] = c_func;
    end else if (s_axi_araddr == R_PIN_IN) begin
      rd_word[15:0] = {pc_s, pb_s};
    end else if (s_axi_araddr == R_IRQ_STAT) begin
      rd_word[EV_W-1:0] = irq_stat;
    end else if (s_axi_araddr == R_IRQ_MASK) begin
      rd_word[EV_W-1:0] = irq_mask;
    end else if (s_axi_araddr == R_HOST_BASE) begin
      rd_word[BASE_W-1:0] = host_base;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Host bus writes land after AXI writes, so the host wins a same-cycle clash.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb        <= PORT_RST;
      pc        <= PORT_RST;
      b_slew    <= '0;
      c_func    <= '0;
      host_base <= '0;
      irq_mask  <= '0;
    end else if (clk_en) begin
      if (aw_take) begin
        if (s_axi_awaddr == R_B_MODE) begin
          pb.mode <= 16'(wmerge(32'(pb.mode), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_B_DIR) begin
          pb.dir <= 8'(wmerge(32'(pb.dir), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_B_OUT) begin
          pb.dout <= 8'(wmerge(32'(pb.dout), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_B_OD) begin
          pb.od <= 8'(wmerge(32'(pb.od), s_axi_wdata, s_axi_wstrb)) & B_OD_MASK;
        end else if (s_axi_awaddr == R_B_SLEW) begin
          b_slew <= 4'(wmerge(32'(b_slew), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_C_MODE) begin
          pc.mode <= 16'(wmerge(32'(pc.mode), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_C_DIR) begin
          pc.dir <= 8'(wmerge(32'(pc.dir), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_C_OUT) begin
          pc.dout <= 8'(wmerge(32'(pc.dout), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_C_OD) begin
          pc.od <= 8'(wmerge(32'(pc.od), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_C_FUNC) begin
          c_func <= 3'(wmerge(32'(c_func), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_IRQ_MASK) begin
          irq_mask <= EV_W'(wmerge(32'(irq_mask), s_axi_wdata, s_axi_wstrb));
        end else if (s_axi_awaddr == R_HOST_BASE) begin
          host_base <= BASE_W'(wmerge(32'(host_base), s_axi_wdata, s_axi_wstrb));
        end
      end
      if (h_commit && hoff == HO_B_OUT) begin
        pb.dout <= hwr_data;
      end else if (h_commit && hoff == HO_C_OUT) begin
        pc.dout <= hwr_data;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic            rdy_q;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign ev_set = {hs == H_IDLE && next_hs == H_RD, h_commit, flash_ready && !rdy_q};
  assign ev_clr = (aw_take && s_axi_awaddr == R_IRQ_STAT && s_axi_wstrb[0])
                  ? s_axi_wdata[EV_W-1:0] : '0;

  // A set in the same cycle as its clear is kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      rdy_q    <= 1'b1;
    end else if (clk_en) begin
      irq_stat <= (irq_stat & ~ev_clr) | ev_set;
      rdy_q    <= flash_ready;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Pin multiplexing
  // ****************************************
  logic [7:0] next_b_out;
  logic [7:0] next_b_oe_n;
  logic [7:0] next_c_out;
  logic [7:0] next_c_oe_n;
  logic       jtag_en;
  logic       enh_en;

  assign jtag_en = c_func[F_JTAG];
  assign enh_en  = jtag_en && c_func[F_ENH];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      {next_b_oe_n[i], next_b_out[i]} = pin_drive(pb.mode[2*i +: 2], pb.dir[i], pb.dout[i],
                                                  output_cell_group_one[i], pb.od[i]);
      {next_c_oe_n[i], next_c_out[i]} = pin_drive(pc.mode[2*i +: 2], pc.dir[i], pc.dout[i],
                                                  output_cell_group_two[i], pc.od[i]);
    end
    // The test role takes the drive of its pins over from whatever general use they had.
    if (jtag_en) begin
      next_c_oe_n[0] = 1'b1;
      next_c_oe_n[1] = 1'b1;
      next_c_oe_n[5] = 1'b1;
      next_c_out[6]  = jtag_tdo;
      next_c_oe_n[6] = 1'b0;
    end
    if (enh_en) begin
      next_c_out[3]  = prog_status_out;
      next_c_oe_n[3] = 1'b0;
      next_c_out[4]  = prog_error_out;
      next_c_oe_n[4] = 1'b0;
    end else if (c_func[F_RDYBSY]) begin
      next_c_out[3]  = flash_ready;
      next_c_oe_n[3] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_pins_out  <= '0;
      port_b_pins_oe_n <= '1;
      port_c_pins_out  <= '0;
      port_c_pins_oe_n <= '1;
    end else if (clk_en) begin
      port_b_pins_out  <= next_b_out;
      port_b_pins_oe_n <= next_b_oe_n;
      port_c_pins_out  <= next_c_out;
      port_c_pins_oe_n <= next_c_oe_n;
    end
  end

  assign port_b_slew_fast = b_slew;

  // PLD inputs only see pins that are set as inputs; pins 2 and 7 suit address bits.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pld_in_b[i] = (pb.mode[2*i +: 2] == MODE_PLD_IN) && pb_s[i];
      pld_in_c[i] = (pc.mode[2*i +: 2] == MODE_PLD_IN) && pc_s[i];
    end
  end

  assign jtag_tms = jtag_en && pc_s[0];
  assign jtag_tck = jtag_en && pc_s[1];
  assign jtag_tdi = jtag_en && pc_s[5];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  sequence s_read_start;
    hs == H_IDLE && hsel && !rd_s;
  endsequence

  a_read_drive: assert property (s_read_start |=> host_data_bus_oe_n == '0)
    else $error("read not driven");
  a_bus_release: assert property (hs != H_RD |-> host_data_bus_oe_n == '1)
    else $error("bus driven outside read");
  a_select_qual: assert property (bms_s && hs == H_IDLE |=> hs == H_IDLE)
    else $error("access without select");
  a_reset_dflt: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> pb == PORT_RST && c_func == '0 && port_c_pins_oe_n == '1)
    else $error("reset defaults wrong");
  a_write_commit: assert property (h_commit && hoff == HO_B_OUT |=> pb.dout == $past(hwr_data)
    ##1 port_b_pins_out == pb.dout || pb.mode[1:0] != MODE_IO)
    else $error("host write lost");
  a_b_open_drain: assert property (pb.mode[15:14] == MODE_IO && pb.dir[7] && pb.od[7] && pb.dout[7]
    |=> port_b_pins_oe_n[7])
    else $error("open drain drove high");
  a_c_open_drain: assert property (!jtag_en && pc.mode[5:4] == MODE_IO && pc.dir[2] && pc.od[2]
    && !pc.dout[2] |=> !port_c_pins_oe_n[2] && !port_c_pins_out[2])
    else $error("open drain low missing");
  a_jtag_pins: assert property (jtag_en |=> !port_c_pins_oe_n[6] && port_c_pins_oe_n[0]
    && port_c_pins_oe_n[1] && port_c_pins_oe_n[5] && port_c_pins_out[6] == $past(jtag_tdo))
    else $error("jtag pin map wrong");
  a_enh_status: assert property (enh_en |=> port_c_pins_out[3] == $past(prog_status_out)
    && port_c_pins_out[4] == $past(prog_error_out))
    else $error("status pins wrong");
  a_rdy_busy: assert property (!enh_en && c_func[F_RDYBSY] |=> !port_c_pins_oe_n[3]
    && port_c_pins_out[3] == $past(flash_ready))
    else $error("ready pin wrong");
  a_pld_input: assert property (pb.mode[1:0] == MODE_PLD_IN |=> port_b_pins_oe_n[0])
    else $error("input pin driven");
  a_c_release: assert property ($fell(jtag_en) && pc.mode[1:0] == MODE_PLD_OUT
    |=> port_c_pins_oe_n[0] == 1'b0 || port_c_pins_out[0] && pc.od[0])
    else $error("pin not returned");
  a_slew_map: assert property (aw_take && s_axi_awaddr == R_B_SLEW && s_axi_wstrb[0]
    |=> port_b_slew_fast == $past(s_axi_wdata[3:0]))
    else $error("slew not applied");

endmodule : dbp_pins

// ===== dbp_dsp.sv
`timescale 1ns/1ps
// ****
// Host processor bus
// ****
module dbp_dsp (
  input  wire logic        clk,  // Clock
  input  wire logic [7:0]  q,    // Device data
  input  wire logic [7:0]  qe_n, // Device enable
  output logic             wr_n, // Write strobe
  output logic             rd_n, // Read strobe
  output logic             sl_n, // Select
  output logic [15:0]      a,    // Address
  output logic [7:0]       d     // Data to device
);
  initial {wr_n, rd_n, sl_n, a, d} = '1;
  // Strobes stay low eight cycles, four times what the device needs to see them.
  task acc(input logic r, s, input logic [15:0] ad, input logic [7:0] wd, output logic [15:0] rv);
    @(posedge clk);
    {sl_n, a, d} <= {s, ad, wd};
    {rd_n, wr_n} <= {!r, r};
    repeat (8) @(posedge clk);
    // A released bus reads back as the inverse of what the device last drove.
    rv = {qe_n, q ^ qe_n};
    {rd_n, wr_n} <= 2'h3;
    repeat (5) @(posedge clk);
    sl_n <= 1'h1;
    d <= ~wd;
    repeat (5) @(posedge clk);
  endtask : acc
endmodule : dbp_dsp

// ===== dbp_pins_tb.sv
`timescale 1ns/1ps
module dbp_pins_tb;
  import dbp_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, jtag_tdo = 1'h0, prog_status_out = 1'h0, prog_error_out = 1'h0;
  logic flash_ready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic jtag_tms, jtag_tck, jtag_tdi, write_strobe_in_n, read_strobe_in_n, byte_space_select_in_n;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, port_b_pins_in = '0, port_c_pins_in = '0, m;
  logic [7:0] output_cell_group_one = '0, output_cell_group_two = '0, host_data_bus_in, host_data_bus_out;
  logic [7:0] host_data_bus_oe_n, port_b_pins_out, port_b_pins_oe_n, port_c_pins_out, port_c_pins_oe_n, pld_in_b, pld_in_c;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v, u, rd;
  logic [15:0] host_address_in, hr;
  logic [3:0] s_axi_wstrb = 4'hF, port_b_slew_fast;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_errors = 0, check_count = 0, k;
  dbp_pins dut (.*);
  dbp_dsp dsp (.clk(aclk), .q(host_data_bus_out), .qe_n(host_data_bus_oe_n), .wr_n(write_strobe_in_n),
    .rd_n(read_strobe_in_n), .sl_n(byte_space_select_in_n), .a(host_address_in), .d(host_data_bus_in));
  initial forever #2.5 aclk = ~aclk;
  // ****
  // Checks and bus cycles
  // ****
  task chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] exp_oe(input logic [7:0] val, input logic [7:0] od);
    return val & od & B_OD_MASK;
  endfunction : exp_oe
  task lim(input int n);
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask : lim
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, dt, 3'h7};
    @(posedge aclk);
    for (k = 0; k < 50 && !s_axi_awready; k++) @(posedge aclk);
    lim(k);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    for (k = 0; k < 50 && !s_axi_bvalid; k++) @(posedge aclk);
    lim(k);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task rdr(input logic [7:0] ad);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    @(posedge aclk);
    for (k = 0; k < 50 && !s_axi_arready; k++) @(posedge aclk);
    lim(k);
    s_axi_arvalid <= 1'h0;
    for (k = 0; k < 50 && !s_axi_rvalid; k++) @(posedge aclk);
    lim(k);
    {rd, rs} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rdr
  task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // Each bus wait has its own bound; this one bounds the run as a whole.
  initial begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
  initial begin
    void'($urandom(69));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    chk("bus oe", 8'hFF, host_data_bus_oe_n);
    chk("b oe", 8'hFF, port_b_pins_oe_n);
    chk("irq", 1'h0, irq);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      {v, u} = {$urandom, $urandom};
      m = u[7:0] & B_OD_MASK;
      wr(R_B_DIR, 32'hFF);
      wr(R_B_OD, u);
      wr(R_B_OUT, v);
      wr(R_B_SLEW, v);
      rdr(R_B_OD);
      chk("od", m, rd);
      chk("slew", v[3:0], port_b_slew_fast);
      chk("b oe", exp_oe(v[7:0], u[7:0]), port_b_pins_oe_n);
      chk("b out", v[7:0] & ~m, port_b_pins_out & ~(v[7:0] & m));
    end
    {output_cell_group_one, port_b_pins_in, port_c_pins_in, jtag_tdo} <= 25'($urandom);
    wr(R_B_OD, 32'h0);
    wr(R_B_MODE, 32'h5555);
    chk("pld out", output_cell_group_one, port_b_pins_out);
    wr(R_B_MODE, 32'hAAAA);
    chk("pld in", port_b_pins_in, pld_in_b);
    clk_en <= 1'h0;
    port_b_pins_in <= ~port_b_pins_in;
    repeat (4) @(posedge aclk);
    chk("freeze", {~port_b_pins_in}, pld_in_b);
    clk_en <= 1'h1;
    wr(R_C_MODE, 32'h8021);
    wr(R_C_FUNC, 32'h1);
    chk("jtag", {port_c_pins_in[5], 3'h0, port_c_pins_in[1:0], jtag_tdo},
        {jtag_tdi, 3'h0, jtag_tck, jtag_tms, port_c_pins_out[6]});
    chk("jtag oe", 8'hBF, port_c_pins_oe_n);
    chk("pld c", port_c_pins_in & 8'h84, pld_in_c);
    {prog_status_out, prog_error_out} <= 2'($urandom);
    wr(R_C_FUNC, 32'h7);
    chk("enh", {prog_error_out, prog_status_out, 2'h0}, {port_c_pins_out[4:3], port_c_pins_oe_n[4:3]});
    flash_ready <= 1'h1;
    wr(R_C_FUNC, 32'h4);
    chk("busy", 1'h1, port_c_pins_out[3]);
    $display("test pins done");
    v = $urandom;
    wr(R_HOST_BASE, v);
    dsp.acc(1'h1, 1'h0, {v[11:0], HO_B_PIN}, 8'h0, hr);
    chk("host rd", {8'h0, port_b_pins_in}, hr);
    dsp.acc(1'h1, 1'h1, {v[11:0], HO_B_PIN}, 8'h0, hr);
    chk("no sel", 8'hFF, hr[15:8]);
    dsp.acc(1'h1, 1'h0, {~v[11:0], HO_B_PIN}, 8'h0, hr);
    chk("off base", 8'hFF, hr[15:8]);
    wr(R_IRQ_MASK, 32'h2);
    dsp.acc(1'h0, 1'h0, {v[11:0], HO_B_OUT}, v[23:16], hr);
    rdr(R_B_OUT);
    chk("host wr", v[23:16], rd);
    chk("irq set", 1'h1, irq);
    wr(R_IRQ_STAT, 32'h2);
    chk("irq clr", 1'h0, irq);
    wr(8'hFC, v);
    chk("unmapped", RESP_SLVERR, rs);
    $display("test host done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(R_C_FUNC);
    chk("func rst", 32'h0, rd);
    chk("c oe rst", 8'hFF, port_c_pins_oe_n);
    $display("test reset again done");
    complete_run();
  end
endmodule : dbp_pins_tb
